// [logic/msbh_map.vh]
// Register map, field positions, reset values and timing constants of the supply and hold block.
`ifndef MSBH_MAP_VH
`define MSBH_MAP_VH
// Register indices; each register is one aligned word, so its byte address is four times this.
`define MSBH_ADDR_SUPPLY 8'h04
`define MSBH_ADDR_HOLD 8'h05
`define MSBH_IDX_HI 9
`define MSBH_IDX_LO 2
`define MSBH_MAP_TOP 10
`define MSBH_CV_BIT 7
`define MSBH_CD_BIT 6
`define MSBH_VSEL_HI 3
`define MSBH_VSEL_LO 0
`define MSBH_OFF_HI 5
`define MSBH_OFF_LO 3
`define MSBH_ON_HI 2
`define MSBH_ON_LO 0
`define MSBH_VSEL_RESET 4'hB
`define MSBH_OFF_RESET 3'h7
`define MSBH_ON_RESET 3'h0
`define MSBH_CLK_KHZ 25000
`define MSBH_T0_MS 5
`define MSBH_STEP_MS 500
`define MSBH_CODE_MAX 3'h5
`define MSBH_HTRANS_NONSEQ 2'h2
`endif

// [logic/msbh_hold_timer.v]
// Button hold timer: measures a steady press against a programmed hold time.
`timescale 1ns/10ps
`default_nettype none
`include "msbh_map.vh"
module msbh_hold_timer
(
  // Clock and reset
  input wire clock_in,
  input wire rstn_in,
  // Control
  input wire press_in,
  input wire [2:0] code_in,
  input wire [31:0] ms_cycles_in,
  // Result
  output reg done_out
);
  // ----------------------------------------------------------------
  // Hold time in milliseconds
  // ----------------------------------------------------------------
  function [31:0] hold_ms;
    input [2:0] code;
    begin
      if (code == 3'h0)
        hold_ms = `MSBH_T0_MS;
      else if (code >= `MSBH_CODE_MAX)
        hold_ms = `MSBH_STEP_MS * {29'h0, `MSBH_CODE_MAX};
      else
        hold_ms = `MSBH_STEP_MS * {29'h0, code};
    end
  endfunction

  reg [31:0] cyc_reg;
  reg [31:0] ms_reg;
  always @(posedge clock_in)
  begin
    if (!rstn_in || !press_in)
    begin
      // A release aborts the pending transition and clears the count.
      cyc_reg <= 32'h0;
      ms_reg <= 32'h0;
      done_out <= 1'b0;
    end
    else if (!done_out)
    begin
      if (cyc_reg >= ms_cycles_in - 32'h1)
      begin
        cyc_reg <= 32'h0;
        ms_reg <= ms_reg + 32'h1;
        if (ms_reg + 32'h1 >= hold_ms(code_in))
          done_out <= 1'b1;
      end
      else
        cyc_reg <= cyc_reg + 32'h1;
    end
  end
endmodule
`default_nettype wire

// [logic/msbh_regs.v]
// Microphone supply and button hold registers on an AHB-Lite slave.
//
// Function
// - Supply bit 7 is read-only: 1 while regulator is in constant voltage mode.
// - Supply bit 6 is read-only: 1 while supply is in constant drop mode.
// - Voltage select bits 3:0, read/write, reset 1011, 1.6 V to 2.9 V steps.
// - Off hold time bits 5:3, reset 111: 5,500,...,2500 ms.
// - On hold time bits 2:0, reset 000, same encoding as off hold time.
// - Hold times apply alike in button, slider and full slider modes.
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "msbh_map.vh"
module msbh_regs
#(
  parameter [31:0] MS_CYCLES = `MSBH_CLK_KHZ
)
(
  // Clock and reset
  input wire clock_in,
  input wire rstn_in,
  // AHB-Lite slave
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  output reg [31:0] hrdata_out,
  output reg hreadyout_out,
  output reg hresp_out,
  // Regulator status and control
  input wire supply_const_voltage_flag_in,
  input wire supply_const_drop_flag_in,
  output reg [3:0] supply_voltage_select_out,
  // Button or slider
  input wire button_in,
  input wire powered_in,
  output reg power_on_req_out,
  output reg power_off_req_out
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [2:0] cv_sync_reg;
  reg [2:0] cd_sync_reg;
  reg [2:0] btn_sync_reg;
  reg cv_reg;
  reg cd_reg;
  reg btn_reg;
  always @(posedge clock_in)
  begin
    if (!rstn_in)
    begin
      cv_sync_reg <= 3'h0;
      cd_sync_reg <= 3'h0;
      btn_sync_reg <= 3'h0;
      cv_reg <= 1'b0;
      cd_reg <= 1'b0;
      btn_reg <= 1'b0;
    end
    else
    begin
      cv_sync_reg <= {cv_sync_reg[1:0], supply_const_voltage_flag_in};
      cd_sync_reg <= {cd_sync_reg[1:0], supply_const_drop_flag_in};
      btn_sync_reg <= {btn_sync_reg[1:0], button_in};
      if (cv_sync_reg[2] == cv_sync_reg[1])
        cv_reg <= cv_sync_reg[2];
      if (cd_sync_reg[2] == cd_sync_reg[1])
        cd_reg <= cd_sync_reg[2];
      if (btn_sync_reg[2] == btn_sync_reg[1])
        btn_reg <= btn_sync_reg[2];
    end
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  reg [2:0] off_time_reg;
  reg [2:0] on_time_reg;
  reg wr_pend_reg;
  reg [7:0] wr_addr_reg;
  wire xfer = hsel_in && hready_in && (htrans_in == `MSBH_HTRANS_NONSEQ);
  wire [7:0] addr_idx = haddr_in[`MSBH_IDX_HI:`MSBH_IDX_LO];
  // Only word-aligned addresses inside the small map reach a register.
  wire mapped = (haddr_in[31:`MSBH_MAP_TOP] == 22'h0) && (haddr_in[1:0] == 2'h0);
  reg [31:0] rd_next;
  always @*
  begin
    rd_next = 32'h0;
    if (!mapped)
      rd_next = 32'h0;
    else if (addr_idx == `MSBH_ADDR_SUPPLY)
    begin
      rd_next[`MSBH_CV_BIT] = cv_reg;
      rd_next[`MSBH_CD_BIT] = cd_reg;
      rd_next[`MSBH_VSEL_HI:`MSBH_VSEL_LO] = supply_voltage_select_out;
    end
    else if (addr_idx == `MSBH_ADDR_HOLD)
    begin
      rd_next[`MSBH_OFF_HI:`MSBH_OFF_LO] = off_time_reg;
      rd_next[`MSBH_ON_HI:`MSBH_ON_LO] = on_time_reg;
    end
  end

  always @(posedge clock_in)
  begin
    if (!rstn_in)
    begin
      hrdata_out <= 32'h0;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h0;
      supply_voltage_select_out <= `MSBH_VSEL_RESET;
      off_time_reg <= `MSBH_OFF_RESET;
      on_time_reg <= `MSBH_ON_RESET;
    end
    else
    begin
      wr_pend_reg <= xfer && hwrite_in && mapped;
      wr_addr_reg <= addr_idx;
      if (xfer && !hwrite_in)
        hrdata_out <= rd_next;
      if (wr_pend_reg && wr_addr_reg == `MSBH_ADDR_SUPPLY)
        supply_voltage_select_out <= hwdata_in[`MSBH_VSEL_HI:`MSBH_VSEL_LO];
      if (wr_pend_reg && wr_addr_reg == `MSBH_ADDR_HOLD)
      begin
        off_time_reg <= hwdata_in[`MSBH_OFF_HI:`MSBH_OFF_LO];
        on_time_reg <= hwdata_in[`MSBH_ON_HI:`MSBH_ON_LO];
      end
    end
  end

  // ----------------------------------------------------------------
  // Hold timing
  // ----------------------------------------------------------------
  // The input mode is not seen here, so one timer serves button, slider and full slider alike.
  wire done;
  wire [2:0] code_sel = powered_in ? off_time_reg : on_time_reg;
  msbh_hold_timer u_timer
  (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .press_in(btn_reg),
    .code_in(code_sel),
    .ms_cycles_in(MS_CYCLES),
    .done_out(done)
  );

  reg done_d_reg;
  always @(posedge clock_in)
  begin
    if (!rstn_in)
    begin
      done_d_reg <= 1'b0;
      power_on_req_out <= 1'b0;
      power_off_req_out <= 1'b0;
    end
    else
    begin
      done_d_reg <= done;
      power_on_req_out <= done && !done_d_reg && !powered_in;
      power_off_req_out <= done && !done_d_reg && powered_in;
    end
  end
endmodule
`default_nettype wire

// [bench/msbh_button_model.sv]
// User push button: held down for a commanded number of cycles.
`timescale 1ns/10ps
`default_nettype none
module msbh_button_model
(
  // Clock and command
  input wire logic clock_in,
  input wire logic [15:0] hold_in,
  input wire logic go_in,
  // Button level
  output logic button_out
);
  logic [15:0] cnt_reg = 16'h0;
  always @(posedge clock_in)
    if (go_in)
      cnt_reg <= hold_in;
    else if (cnt_reg != 16'h0)
      cnt_reg <= cnt_reg - 16'h1;
  assign button_out = cnt_reg != 16'h0;
endmodule
`default_nettype wire

// [bench/msbh_regs_properties.sv]
// Port checks of the supply and hold register block.
`timescale 1ns/10ps
`default_nettype none
module msbh_regs_properties
(
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic [3:0] supply_voltage_select_out,
  input wire logic button_in,
  input wire logic powered_in,
  input wire logic power_on_req_out,
  input wire logic power_off_req_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  a_vsel_reset: assert property ($rose(rstn_in) |-> supply_voltage_select_out == 4'hB)
    else $error("vsel reset");
  a_bus_okay: assert property (hreadyout_out && !hresp_out)
    else $error("bus stall");
  a_on_unpowered: assert property (power_on_req_out |-> !powered_in && !power_off_req_out)
    else $error("on pulse");
  a_off_powered: assert property (power_off_req_out |-> powered_in)
    else $error("off pulse");
  a_pulse_once: assert property (power_on_req_out || power_off_req_out |=>
    !power_on_req_out && !power_off_req_out)
    else $error("pulse long");
  a_press_recent: assert property (power_on_req_out || power_off_req_out |->
    $past(button_in, 8))
    else $error("no press");
  a_press_held: assert property (power_on_req_out || power_off_req_out |->
    $past(button_in, 40))
    else $error("short hold");
endmodule
bind msbh_regs msbh_regs_properties chk_u (.*);
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the supply and hold register block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 0, rstn = 0, hsel = 0, hwrite = 0, cv = 0, cd = 0, pwr = 0, go = 0;
  logic btn, rdy, resp, onp, offp;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [3:0] vsel;
  logic [15:0] hold = 16'h0;
  int miscompares = 0, compares = 0, ons = 0, offs = 0;
  always #20 clk = ~clk;
  always @(posedge clk) ons <= ons + onp;
  always @(posedge clk) offs <= offs + offp;
  msbh_regs #(.MS_CYCLES(32'hA)) dut_u (.clock_in(clk), .rstn_in(rstn), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(rdy), .hrdata_out(rd), .hreadyout_out(rdy),
    .hresp_out(resp), .supply_const_voltage_flag_in(cv), .supply_const_drop_flag_in(cd),
    .supply_voltage_select_out(vsel), .button_in(btn), .powered_in(pwr),
    .power_on_req_out(onp), .power_off_req_out(offp));
  msbh_button_model btn_u (.clock_in(clk), .hold_in(hold), .go_in(go), .button_out(btn));
  task chk(input logic [31:0] seen, exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task give_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // The slave never stretches a phase (hreadyout_out stays high), but every wait is bounded all the same.
  task wait_rdy;
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end while (rdy !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      miscompares++;
      give_verdict;
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy;
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    r = rd;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1, a, d, r);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
    logic [31:0] r;
    xfer(0, a, 32'h0, r);
    chk(r, e, what);
  endtask
  task press(input logic [15:0] n, input logic p);
    pwr <= p;
    hold <= n;
    go <= 1;
    @(posedge clk);
    go <= 0;
    repeat (n + 20) @(posedge clk);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    rd_chk(8'h10, 32'h0B, "supply reset");
    rd_chk(8'h14, 32'h38, "hold reset");
    chk(vsel, 32'hB, "vsel reset");
    $display("reset test done");
    cv <= 1;
    wr(8'h10, 32'hFFFFFFCD);
    repeat (8) @(posedge clk);
    rd_chk(8'h10, 32'h8D, "supply cv");
    chk(vsel, 32'hD, "vsel pins");
    cv <= 0;
    cd <= 1;
    repeat (8) @(posedge clk);
    rd_chk(8'h10, 32'h4D, "supply cd");
    wr(8'h14, 32'hFFFFFFFF);
    rd_chk(8'h14, 32'h3F, "hold all");
    wr(8'h20, 32'hFFFFFFFF);
    rd_chk(8'h20, 32'h0, "unmapped");
    $display("register test done");
    wr(8'h14, 32'h08);
    press(16'h50, 0);
    chk(ons, 32'h1, "on pulse");
    press(16'h1E, 0);
    chk(ons, 32'h1, "short on");
    press(16'h1194, 1);
    chk(offs, 32'h0, "short off");
    press(16'h1450, 1);
    chk(offs, 32'h1, "off pulse");
    $display("hold test done");
    give_verdict;
  end
endmodule
`default_nettype wire
